// *** dx_pkg.sv ***
/*
 * shared constants for the divide and exclusive-or execution block:
 * instruction field positions, mode codes, flag positions, timing.
 * assumes nothing beyond a systemverilog compiler.
 */
`default_nettype none
package dx_pkg;
    localparam int DATA_W = 32;
    localparam int DIV_STEPS = 64;
    // extension word layout
    localparam int EXT_QREG_HI = 14;
    localparam int EXT_QREG_LO = 12;
    localparam int EXT_SIGNED_BIT = 11;
    localparam int EXT_SIZE_BIT = 10;
    localparam int EXT_ZERO_HI = 9;
    localparam int EXT_ZERO_LO = 3;
    localparam int EXT_RREG_HI = 2;
    localparam int EXT_RREG_LO = 0;
    // effective address modes
    localparam logic [2:0] MODE_DREG = 3'h0;
    localparam logic [2:0] MODE_AREG = 3'h1;
    localparam logic [2:0] MODE_EXT = 3'h7;
    localparam logic [2:0] EXTREG_ABSW = 3'h0;
    localparam logic [2:0] EXTREG_ABSL = 3'h1;
    localparam logic [2:0] EXTREG_PCD = 3'h2;
    localparam logic [2:0] EXTREG_PCX = 3'h3;
    localparam logic [2:0] EXTREG_IMM = 3'h4;
    // register xor opmodes
    localparam logic [2:0] OPM_BYTE = 3'h4;
    localparam logic [2:0] OPM_WORD = 3'h5;
    localparam logic [2:0] OPM_LONG = 3'h6;
    // immediate xor size field
    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_WORD = 2'h1;
    localparam logic [1:0] SZ_LONG = 2'h2;
    // condition flag positions
    localparam int FLAG_C = 0;
    localparam int FLAG_V = 1;
    localparam int FLAG_Z = 2;
    localparam int FLAG_N = 3;
    localparam int FLAG_X = 4;
    localparam logic [4:0] FLAGS_RESET = 5'h00;
    localparam logic [4:0] FLAG_IMPL_MASK = 5'h1f;
    // operation codes from the decoder
    typedef enum logic [2:0] {
        OP_NONE, OP_UDIV_W, OP_UDIV_L, OP_REG_XOR, OP_IMM_XOR, OP_FLAG_XOR
    } op_e;
endpackage
`default_nettype wire

// *** dx_divider.sv ***
/*
 * restoring unsigned divider, one quotient bit per clock, 64 by 32 bits.
 * assumes start is only pulsed while idle and the divisor is nonzero.
 */
`timescale 1ns/100ps
`default_nettype none
module dx_divider #(
    parameter int WIDTH = 32
) (
    input wire logic core_clk, // system clock
    input wire logic reset, // synchronous reset, active high
    input wire logic start, // one-cycle start pulse
    input wire logic [2*WIDTH-1:0] dividend, // dividend
    input wire logic [WIDTH-1:0] divisor, // divisor, nonzero
    output logic done, // one-cycle completion pulse
    output logic [2*WIDTH-1:0] quotient, // full width quotient
    output logic [WIDTH-1:0] remainder // remainder
);
    if (WIDTH < 2) begin : g_width_check
        $error("divider width too small");
    end

    typedef struct packed {
        logic busy;
        logic done;
        logic [$clog2(2*WIDTH+1)-1:0] cnt;
        logic [2*WIDTH-1:0] quo;
        logic [WIDTH:0] rem;
        logic [WIDTH-1:0] dvs;
    } st_s;

    st_s st_r;
    st_s st_nxt;
    logic [WIDTH:0] trial;

    always_comb begin
        st_nxt = st_r;
        st_nxt.done = 1'b0;
        trial = '0;
        if (start && !st_r.busy) begin
            st_nxt.busy = 1'b1;
            st_nxt.cnt = '0;
            st_nxt.quo = dividend;
            st_nxt.rem = '0;
            st_nxt.dvs = divisor;
        end else if (st_r.busy) begin
            // shift one dividend bit into the partial remainder
            trial = {st_r.rem[WIDTH-1:0], st_r.quo[2*WIDTH-1]};
            st_nxt.quo = {st_r.quo[2*WIDTH-2:0], 1'b0};
            if (trial >= {1'b0, st_r.dvs}) begin
                st_nxt.rem = trial - {1'b0, st_r.dvs};
                st_nxt.quo[0] = 1'b1;
            end else begin
                st_nxt.rem = trial;
            end
            st_nxt.cnt = st_r.cnt + 1'b1;
            if (st_r.cnt == ($clog2(2*WIDTH+1))'(2*WIDTH-1)) begin
                st_nxt.busy = 1'b0;
                st_nxt.done = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign done = st_r.done;
    assign quotient = st_r.quo;
    assign remainder = st_r.rem[WIDTH-1:0];

    done_alone_a: assert property (@(posedge core_clk) disable iff (reset)
        st_r.done |-> !st_r.busy) else $error("divider done while busy");
endmodule // dx_divider
`default_nettype wire

// *** dx_exec.sv ***
/*
 * execution unit for unsigned divide (word and long forms) and the
 * exclusive-or family: register source, immediate, and into the flags.
 * assumes the decoder presents operands and a one-cycle issue pulse
 * with all inputs on core_clk, and writes back from the result ports.
 */
// Behaviour
// - word divide flags overflow when quotient exceeds 16-bit signed range
// - long divide low dividend from quotient register, quotient written there
// - size bit 0 gives 32-bit dividend, 1 gives 64-bit pair
// - remainder register gets remainder unless it equals quotient register
// - size 1 takes dividend high half from remainder register
// - long divide flags overflow when quotient exceeds 32 bits unsigned
// - long divide source accepts data modes, rejects address register direct
// - register xor writes operand xor source back, opmode picks size
// - register xor source is one of eight data registers
// - register xor destination is always the effective address operand
// - register xor destination limited to data alterable modes
// - xor sets n from msb, z on zero, clears v and c, keeps x
// - immediate xor combines size-matched immediate with destination
// - immediate size 00 byte, 01 word, 10 long
// - immediate from low byte, one word, or two words by size
// - immediate xor destination limited to data alterable modes
// - flags xor takes byte immediate into all implemented flag bits
// - immediate bits 4..0 toggle x n z v c respectively
// - zero divisor raises a trap, no quotient
`timescale 1ns/100ps
`default_nettype none
module dx_exec #(
    parameter int WIDTH = 32
) (
    input wire logic core_clk, // system clock, 100 MHz
    input wire logic reset, // synchronous reset, active high
    input wire logic issue, // one-cycle request pulse
    input wire dx_pkg::op_e op, // operation to execute
    input wire logic [15:0] opword, // first instruction word
    input wire logic [15:0] ext_word, // extension word of long divide
    input wire logic [15:0] imm_hi, // first immediate extension word
    input wire logic [15:0] imm_lo, // second immediate extension word
    input wire logic [WIDTH-1:0] src_data, // divisor or ea source operand
    input wire logic [WIDTH-1:0] dst_data, // ea destination operand
    input wire logic [WIDTH-1:0] dreg_q, // data register named by quotient field
    input wire logic [WIDTH-1:0] dreg_r, // data register named by remainder field
    input wire logic [WIDTH-1:0] dreg_src, // data register named by register field
    input wire logic [4:0] flags_in, // condition flags from the status register
    output logic busy, // operation in progress
    output logic done, // one-cycle completion pulse
    output logic illegal, // one-cycle pulse: encoding refused
    output logic div_zero_trap, // one-cycle pulse: divisor was zero
    output logic [4:0] flags_out, // condition flags after the operation
    output logic flags_we, // flags_out valid with done
    output logic [WIDTH-1:0] ea_wdata, // result for the ea destination
    output logic ea_we, // write ea destination
    output logic [WIDTH-1:0] q_wdata, // quotient write data
    output logic q_we, // write quotient register
    output logic [2:0] q_wsel, // quotient register number
    output logic [WIDTH-1:0] r_wdata, // remainder write data
    output logic r_we, // write remainder register
    output logic [2:0] r_wsel // remainder register number
);
    if (WIDTH != 32) begin : g_width_check
        $error("execution unit supports only 32-bit data");
    end

    typedef enum logic [1:0] {IDLE, DIVIDE, FINISH} state_e;

    typedef struct packed {
        state_e state;
        logic word_form;
        logic [4:0] flags;
        logic busy;
        logic done;
        logic illegal;
        logic trap;
        logic flags_we;
        logic ea_we;
        logic [WIDTH-1:0] ea_data;
        logic q_we;
        logic [WIDTH-1:0] q_data;
        logic [2:0] q_sel;
        logic r_we;
        logic [WIDTH-1:0] r_data;
        logic [2:0] r_sel;
        logic q_pend;
        logic r_pend;
    } st_s;

    st_s st_r;
    st_s st_nxt;

    // data alterable destination: not address direct, not pc relative, not immediate
    function automatic logic data_alterable(input logic [2:0] mode, input logic [2:0] reg_f);
        logic ok;
        ok = 1'b1;
        if (mode == dx_pkg::MODE_AREG) ok = 1'b0;
        if (mode == dx_pkg::MODE_EXT && reg_f != dx_pkg::EXTREG_ABSW
                && reg_f != dx_pkg::EXTREG_ABSL) ok = 1'b0;
        return ok;
    endfunction

    // data modes: everything except address direct and unused extension codes
    function automatic logic data_mode(input logic [2:0] mode, input logic [2:0] reg_f);
        logic ok;
        ok = (mode != dx_pkg::MODE_AREG);
        if (mode == dx_pkg::MODE_EXT && reg_f > dx_pkg::EXTREG_IMM) ok = 1'b0;
        return ok;
    endfunction

    // xor flag update at a given size
    function automatic logic [4:0] logic_flags(input logic [4:0] f, input logic [31:0] res,
                                              input logic [1:0] sz);
        logic [4:0] o;
        o = f;
        o[dx_pkg::FLAG_V] = 1'b0;
        o[dx_pkg::FLAG_C] = 1'b0;
        unique case (sz)
            dx_pkg::SZ_BYTE: begin
                o[dx_pkg::FLAG_N] = res[7];
                o[dx_pkg::FLAG_Z] = (res[7:0] == 8'h00);
            end
            dx_pkg::SZ_WORD: begin
                o[dx_pkg::FLAG_N] = res[15];
                o[dx_pkg::FLAG_Z] = (res[15:0] == 16'h0000);
            end
            default: begin
                o[dx_pkg::FLAG_N] = res[31];
                o[dx_pkg::FLAG_Z] = (res == 32'h00000000);
            end
        endcase
        return o;
    endfunction

    // merge a sized result into the destination's untouched upper bits
    function automatic logic [31:0] sized_merge(input logic [31:0] old, input logic [31:0] res,
                                                input logic [1:0] sz);
        logic [31:0] o;
        o = res;
        if (sz == dx_pkg::SZ_BYTE) o = {old[31:8], res[7:0]};
        if (sz == dx_pkg::SZ_WORD) o = {old[31:16], res[15:0]};
        return o;
    endfunction

    wire logic [2:0] ea_mode = opword[5:3];
    wire logic [2:0] ea_reg = opword[2:0];
    wire logic [2:0] opmode = opword[8:6];
    wire logic [1:0] isize = opword[7:6];
    wire logic [2:0] ext_q = ext_word[dx_pkg::EXT_QREG_HI:dx_pkg::EXT_QREG_LO];
    wire logic [2:0] ext_r = ext_word[dx_pkg::EXT_RREG_HI:dx_pkg::EXT_RREG_LO];
    wire logic ext_size = ext_word[dx_pkg::EXT_SIZE_BIT];

    logic div_start;
    logic [2*WIDTH-1:0] div_dividend;
    logic div_done;
    logic [2*WIDTH-1:0] div_quo;
    logic [WIDTH-1:0] div_rem;
    logic [WIDTH-1:0] div_divisor;

    dx_divider #(.WIDTH(WIDTH)) u_div (
        .core_clk(core_clk),
        .reset(reset),
        .start(div_start),
        .dividend(div_dividend),
        .divisor(div_divisor),
        .done(div_done),
        .quotient(div_quo),
        .remainder(div_rem)
    );

    logic [1:0] rsz;
    logic [WIDTH-1:0] imm_val;
    logic [WIDTH-1:0] xres;

    always_comb begin
        st_nxt = st_r;
        st_nxt.done = 1'b0;
        st_nxt.illegal = 1'b0;
        st_nxt.trap = 1'b0;
        st_nxt.flags_we = 1'b0;
        st_nxt.ea_we = 1'b0;
        st_nxt.q_we = 1'b0;
        st_nxt.r_we = 1'b0;
        div_start = 1'b0;
        div_dividend = '0;
        div_divisor = src_data;
        rsz = dx_pkg::SZ_LONG;
        imm_val = '0;
        xres = '0;
        unique case (st_r.state)
            IDLE: begin
                if (issue) begin
                    st_nxt.flags = flags_in;
                    unique case (op)
                        dx_pkg::OP_REG_XOR: begin
                            unique case (opmode)
                                dx_pkg::OPM_BYTE: rsz = dx_pkg::SZ_BYTE;
                                dx_pkg::OPM_WORD: rsz = dx_pkg::SZ_WORD;
                                default: rsz = dx_pkg::SZ_LONG;
                            endcase
                            // source from a data register only, result to the ea
                            xres = dst_data ^ dreg_src;
                            if (!data_alterable(ea_mode, ea_reg)
                                    || !(opmode inside {dx_pkg::OPM_BYTE, dx_pkg::OPM_WORD,
                                                        dx_pkg::OPM_LONG})) begin
                                st_nxt.illegal = 1'b1;
                            end else begin
                                st_nxt.ea_data = sized_merge(dst_data, xres, rsz);
                                st_nxt.ea_we = 1'b1;
                                st_nxt.flags = logic_flags(flags_in, xres, rsz);
                                st_nxt.flags_we = 1'b1;
                                st_nxt.done = 1'b1;
                            end
                        end
                        dx_pkg::OP_IMM_XOR: begin
                            rsz = isize;
                            unique case (isize)
                                dx_pkg::SZ_BYTE: imm_val = {24'h000000, imm_hi[7:0]};
                                dx_pkg::SZ_WORD: imm_val = {16'h0000, imm_hi};
                                default: imm_val = {imm_hi, imm_lo};
                            endcase
                            xres = dst_data ^ imm_val;
                            if (isize == 2'h3 || !data_alterable(ea_mode, ea_reg)) begin
                                st_nxt.illegal = 1'b1;
                            end else begin
                                st_nxt.ea_data = sized_merge(dst_data, xres, rsz);
                                st_nxt.ea_we = 1'b1;
                                st_nxt.flags = logic_flags(flags_in, xres, rsz);
                                st_nxt.flags_we = 1'b1;
                                st_nxt.done = 1'b1;
                            end
                        end
                        dx_pkg::OP_FLAG_XOR: begin
                            // bit 4..0 toggle x n z v c
                            st_nxt.flags = flags_in ^ (imm_hi[4:0] & dx_pkg::FLAG_IMPL_MASK);
                            st_nxt.flags_we = 1'b1;
                            st_nxt.done = 1'b1;
                        end
                        dx_pkg::OP_UDIV_W, dx_pkg::OP_UDIV_L: begin
                            st_nxt.word_form = (op == dx_pkg::OP_UDIV_W);
                            st_nxt.q_pend = 1'b0;
                            st_nxt.r_pend = 1'b0;
                            if (op == dx_pkg::OP_UDIV_W) begin
                                st_nxt.q_sel = opword[11:9];
                                st_nxt.r_sel = opword[11:9];
                                div_dividend = {32'h00000000, dreg_q};
                                div_divisor = {16'h0000, src_data[15:0]};
                            end else begin
                                st_nxt.q_sel = ext_q;
                                st_nxt.r_sel = ext_r;
                                // dividend width from size bit
                                div_dividend = ext_size ? {dreg_r, dreg_q}
                                                        : {32'h00000000, dreg_q};
                            end
                            if (!data_mode(ea_mode, ea_reg)
                                    || (op == dx_pkg::OP_UDIV_L
                                        && (ext_word[15] || ext_word[dx_pkg::EXT_SIGNED_BIT]
                                            || ext_word[dx_pkg::EXT_ZERO_HI:dx_pkg::EXT_ZERO_LO]
                                               != 7'h00))) begin
                                st_nxt.illegal = 1'b1;
                            end else if (div_divisor == '0) begin
                                st_nxt.trap = 1'b1;
                            end else begin
                                div_start = 1'b1;
                                st_nxt.busy = 1'b1;
                                st_nxt.state = DIVIDE;
                            end
                        end
                        default: begin
                            st_nxt.illegal = 1'b1;
                        end
                    endcase
                end
            end
            DIVIDE: begin
                if (div_done) begin
                    st_nxt.flags[dx_pkg::FLAG_C] = 1'b0;
                    if (st_r.word_form ? (div_quo[63:15] != 49'h0)
                                       : (div_quo[63:32] != 32'h0)) begin
                        st_nxt.flags[dx_pkg::FLAG_V] = 1'b1;
                    end else begin
                        st_nxt.flags[dx_pkg::FLAG_V] = 1'b0;
                        st_nxt.q_pend = 1'b1;
                        if (st_r.word_form) begin
                            st_nxt.q_data = {div_rem[15:0], div_quo[15:0]};
                            st_nxt.flags[dx_pkg::FLAG_N] = div_quo[15];
                            st_nxt.flags[dx_pkg::FLAG_Z] = (div_quo[15:0] == 16'h0000);
                        end else begin
                            st_nxt.q_data = div_quo[31:0];
                            st_nxt.r_data = div_rem;
                            st_nxt.r_pend = (st_r.r_sel != st_r.q_sel);
                            st_nxt.flags[dx_pkg::FLAG_N] = div_quo[31];
                            st_nxt.flags[dx_pkg::FLAG_Z] = (div_quo[31:0] == 32'h0);
                        end
                    end
                    st_nxt.state = FINISH;
                end
            end
            FINISH: begin
                // register writes pulse together with done
                st_nxt.q_we = st_r.q_pend;
                st_nxt.r_we = st_r.r_pend;
                st_nxt.flags_we = 1'b1;
                st_nxt.done = 1'b1;
                st_nxt.busy = 1'b0;
                st_nxt.state = IDLE;
            end
            default: st_nxt.state = IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            st_r <= '{state: IDLE, flags: dx_pkg::FLAGS_RESET, default: '0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign busy = st_r.busy;
    assign done = st_r.done;
    assign illegal = st_r.illegal;
    assign div_zero_trap = st_r.trap;
    assign flags_out = st_r.flags;
    assign flags_we = st_r.flags_we;
    assign ea_wdata = st_r.ea_data;
    assign ea_we = st_r.ea_we;
    assign q_wdata = st_r.q_data;
    assign q_we = st_r.q_we;
    assign q_wsel = st_r.q_sel;
    assign r_wdata = st_r.r_data;
    assign r_we = st_r.r_we;
    assign r_wsel = st_r.r_sel;

    xor_flags_a: assert property (@(posedge core_clk) disable iff (reset)
        ea_we |-> !flags_out[dx_pkg::FLAG_V] && !flags_out[dx_pkg::FLAG_C])
        else $error("xor left v or c set");
    xor_keeps_x_a: assert property (@(posedge core_clk) disable iff (reset)
        issue && st_r.state == IDLE && op == dx_pkg::OP_REG_XOR |=>
            (!ea_we || flags_out[dx_pkg::FLAG_X] == $past(flags_in[dx_pkg::FLAG_X])))
        else $error("xor changed extend");
    flag_toggle_a: assert property (@(posedge core_clk) disable iff (reset)
        issue && st_r.state == IDLE && op == dx_pkg::OP_FLAG_XOR |=>
            flags_out == ($past(flags_in) ^ $past(imm_hi[4:0])) && flags_we)
        else $error("flag xor wrong");
    rxor_areg_a: assert property (@(posedge core_clk) disable iff (reset)
        issue && st_r.state == IDLE && op == dx_pkg::OP_REG_XOR
            && ea_mode == dx_pkg::MODE_AREG |=> illegal && !ea_we)
        else $error("address direct destination accepted");
    divl_areg_a: assert property (@(posedge core_clk) disable iff (reset)
        issue && st_r.state == IDLE && op == dx_pkg::OP_UDIV_L
            && ea_mode == dx_pkg::MODE_AREG |=> illegal && !busy)
        else $error("address direct divisor accepted");
    zero_trap_a: assert property (@(posedge core_clk) disable iff (reset)
        div_zero_trap |-> !busy && !q_we && !r_we)
        else $error("trap with divide activity");
    ovf_hold_a: assert property (@(posedge core_clk) disable iff (reset)
        done && flags_we && flags_out[dx_pkg::FLAG_V] && !ea_we |-> !q_we && !r_we)
        else $error("overflow wrote a register");
    same_reg_a: assert property (@(posedge core_clk) disable iff (reset)
        r_we |-> r_wsel != q_wsel && q_we)
        else $error("remainder written over quotient");
    div_bound_a: assert property (@(posedge core_clk) disable iff (reset)
        $rose(busy) |-> ##[66:67] done)
        else $error("divide did not finish in time");
endmodule // dx_exec
`default_nettype wire

// *** dreg_model.sv ***
/* data register file standing in for the decoder's operand access.
   assumes writes arrive from the execution unit's result ports. */
`timescale 1ns/100ps
`default_nettype none
module dreg_model (
    input wire logic core_clk, // system clock
    input wire logic wdiv, // word divide decoded
    input wire logic [15:0] opword, // instruction word
    input wire logic [15:0] ext_word, // extension word
    input wire logic q_we, // quotient write
    input wire logic [2:0] q_wsel, // quotient register
    input wire logic [31:0] q_wdata, // quotient value
    input wire logic r_we, // remainder write
    input wire logic [2:0] r_wsel, // remainder register
    input wire logic [31:0] r_wdata, // remainder value
    output logic [31:0] dreg_q, // quotient field register
    output logic [31:0] dreg_r, // remainder field register
    output logic [31:0] dreg_src // register field register
);
    logic [31:0] regs [8];
    assign dreg_q = regs[wdiv ? opword[11:9] : ext_word[14:12]];
    assign dreg_r = regs[ext_word[2:0]];
    assign dreg_src = regs[opword[11:9]];
    always @(posedge core_clk) begin
        if (q_we) regs[q_wsel] <= q_wdata;
        if (r_we) regs[r_wsel] <= r_wdata;
    end
endmodule // dreg_model
`default_nettype wire

// *** tb_top.sv ***
/* self-checking bench for the divide and exclusive-or unit.
   assumes dreg_model supplies the data registers. */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic issue = 1'b0;
    dx_pkg::op_e op = dx_pkg::OP_NONE;
    logic [15:0] opword = '0, ext_word = '0, imm_hi = '0, imm_lo = '0;
    logic [31:0] src_data = '0, dst_data = '0;
    logic [4:0] flags_in = 5'h10;
    logic [31:0] dreg_q, dreg_r, dreg_src, ea_wdata, q_wdata, r_wdata, m, r;
    logic [4:0] flags_out;
    logic busy, done, illegal, div_zero_trap, flags_we, ea_we, q_we, r_we, bz;
    logic [2:0] q_wsel, r_wsel;
    int n_fail = 0;
    int check_count = 0;
    always #5 core_clk = ~core_clk;
    dx_exec uut (.core_clk, .reset, .issue, .op, .opword, .ext_word, .imm_hi, .imm_lo,
        .src_data, .dst_data, .dreg_q, .dreg_r, .dreg_src, .flags_in, .busy, .done,
        .illegal, .div_zero_trap, .flags_out, .flags_we, .ea_wdata, .ea_we, .q_wdata,
        .q_we, .q_wsel, .r_wdata, .r_we, .r_wsel);
    dreg_model dm (.core_clk, .wdiv(op == dx_pkg::OP_UDIV_W), .opword, .ext_word, .q_we,
        .q_wsel, .q_wdata, .r_we, .r_wsel, .r_wdata, .dreg_q, .dreg_r, .dreg_src);
    task automatic complete_run;
        $display("checks %0d failures %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic go(input dx_pkg::op_e o, input logic [15:0] ow, ew, ih, il,
        input logic [31:0] sd, dd);
        int i;
        op = o; opword = ow; ext_word = ew; imm_hi = ih; imm_lo = il;
        src_data = sd; dst_data = dd; issue = 1'b1;
        @(negedge core_clk) issue = 1'b0;
        bz = busy;
        for (i = 0; i < 90 && (done | illegal | div_zero_trap) !== 1'b1; i++)
            @(negedge core_clk);
        if (i == 90) begin
            n_fail++;
            complete_run;
        end
    endtask
    // divide: control {trap, q_we, r_we}, data only where written
    task automatic dv(input dx_pkg::op_e o, input logic [15:0] ow, ew,
        input logic [31:0] sd, eq, er, input logic [4:0] ef, input logic [2:0] ec);
        go(o, ow, ew, 16'h0, 16'h0, sd, 32'h0);
        chk("ctl", ec, {div_zero_trap, q_we, r_we});
        chk("bsy", {!ec[2], 1'b0, !ec[2]}, {bz, busy, flags_we});
        if (q_we === 1'b1) chk("quo", eq, q_wdata);
        if (r_we === 1'b1) chk("rem", er, r_wdata);
        if (div_zero_trap !== 1'b1) chk("flg", ef, flags_out);
    endtask
    dx_pkg::op_e bop [5] = '{dx_pkg::OP_IMM_XOR, dx_pkg::OP_REG_XOR, dx_pkg::OP_IMM_XOR,
        dx_pkg::OP_UDIV_L, dx_pkg::OP_UDIV_L};
    logic [15:0] bow [5] = '{16'h0ac0, 16'hb108, 16'h0a3a, 16'h4c48, 16'h4c40};
    initial begin
        repeat (6) @(negedge core_clk);
        reset = 1'b0;
        dm.regs[0] = 32'h80f080f0;
        for (int k = 0; k < 6; k++) begin
            m = k % 3 == 0 ? 32'hff : k % 3 == 1 ? 32'hffff : 32'hffffffff;
            go(k < 3 ? dx_pkg::OP_REG_XOR : dx_pkg::OP_IMM_XOR, k < 3 ? {4'hb, 3'h0, 3'(k + 4),
                6'h0} : {8'h0a, 2'(k - 3), 6'h0}, 16'h0, 16'h80f0, 16'h80f0, 32'h0,
                32'h123480f0);
            r = (32'h123480f0 & ~m) | ((32'h123480f0 ^ 32'h80f080f0) & m);
            chk("ea", r, ea_wdata);
            chk("flags", {ea_we, flags_we, 1'b1, (r & (m ^ (m >> 1))) != 0,
                (r & m) == 0, 2'h0}, {ea_we, flags_we, flags_out});
        end
        for (int k = 0; k < 5; k++) begin
            go(bop[k], bow[k], k == 4 ? 16'h1802 : 16'h1002, 0, 0, 7, 0);
            chk("bad", 2'b10, {illegal, ea_we | q_we});
        end
        go(dx_pkg::OP_FLAG_XOR, 16'h003c, 16'h0, 16'h0015, 16'h0, 0, 0);
        chk("flagxor", 6'h25, {flags_we, flags_out});
        flags_in = 5'h0f;
        dm.regs[1] = 32'd100;
        dm.regs[3] = 32'h1;
        dm.regs[4] = 32'h0;
        dm.regs[5] = 32'd9;
        dm.regs[6] = 32'h00010001;
        dv(dx_pkg::OP_UDIV_L, 16'h4c40, 16'h1002, 7, 14, 2, 5'h00, 3'h3);
        chk("sel", 6'o12, {q_wsel, r_wsel});
        dv(dx_pkg::OP_UDIV_L, 16'h4c40, 16'h4403, 2, 32'h80000000, 0, 5'h08, 3'h3);
        @(negedge core_clk);
        dm.regs[3] = 32'h5;
        dv(dx_pkg::OP_UDIV_L, 16'h4c40, 16'h4403, 2, 0, 0, 5'h0e, 3'h0);
        dv(dx_pkg::OP_UDIV_L, 16'h4c40, 16'h1002, 0, 0, 0, 5'h10, 3'h4);
        dv(dx_pkg::OP_UDIV_L, 16'h4c40, 16'h5005, 4, 2, 0, 5'h00, 3'h2);
        @(negedge core_clk);
        chk("reg", 32'h2, dm.regs[5]);
        dv(dx_pkg::OP_UDIV_W, 16'h8cc0, 16'h0, 2, 0, 0, 5'h0e, 3'h0);
        dv(dx_pkg::OP_UDIV_W, 16'h8cc0, 16'h0, 3, 32'h00025555, 0, 5'h00, 3'h2);
        complete_run;
    end
endmodule // tb_top
`default_nettype wire
